/* File: src/spimsp_map.vh */
// register offsets, field positions and reset values of the serial port
`ifndef SPIMSP_MAP_VH
`define SPIMSP_MAP_VH
`define SPIMSP_OFF_CTL1     8'h00
`define SPIMSP_OFF_CTL2     8'h04
`define SPIMSP_OFF_RATE     8'h08
`define SPIMSP_OFF_FLAG     8'h0c
`define SPIMSP_OFF_DATA     8'h10
`define SPIMSP_OFF_PORT     8'h14
`define SPIMSP_OFF_DIR      8'h18
`define SPIMSP_C1_IRQEN     7
`define SPIMSP_C1_ENABLE    6
`define SPIMSP_C1_ODRAIN    5
`define SPIMSP_C1_MASTER    4
`define SPIMSP_C1_CLOCK_POLARITY      3
`define SPIMSP_C1_CLOCK_PHASE      2
`define SPIMSP_C1_SELECT_OUTPUT_ENABLE      1
`define SPIMSP_C1_LSB_FIRST_SELECT      0
`define SPIMSP_FL_DONE      7
`define SPIMSP_FL_WRITE_COLLISION_FLAG      6
`define SPIMSP_FL_MODE_FAULT_FLAG      4
`define SPIMSP_PIN_MISO     0
`define SPIMSP_PIN_MOSI     1
`define SPIMSP_PIN_SCK      2
`define SPIMSP_PIN_SS       3
`define SPIMSP_RST_CTL1     8'h00
`define SPIMSP_RST_RATE     3'h0
`define SPIMSP_RST_DIR      4'h0
`define SPIMSP_LAST_EDGE    4'hf
`define SPIMSP_LAST_BIT     3'h7
`endif

/* File: src/spimsp_sync.v */
// three-flop pin synchroniser, output follows once the last two stages agree
`default_nettype none
module spimsp_sync #(
   parameter INIT = 1'b0
) (
   input  wire pclk,
   input  wire presetn,
   input  wire pin_in,
   output wire level
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   reg lvl_ff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff  <= INIT;
         s2_ff  <= INIT;
         s3_ff  <= INIT;
         lvl_ff <= INIT;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
         end
      end
   end
   assign level = lvl_ff;
endmodule
`default_nettype wire

/* File: src/spimsp_pin.v */
// registered driver of one shared port pin, push-pull or open-drain
`default_nettype none
module spimsp_pin #(
   parameter RST_OUT = 1'b0
) (
   input  wire pclk,
   input  wire presetn,
   input  wire port_own,
   input  wire port_drive,
   input  wire port_val,
   input  wire gp_dir,
   input  wire gp_val,
   input  wire odrain,
   output reg  pin_out,
   output reg  pin_oe
);
   wire drive;
   wire val;
   assign drive = port_own ? port_drive : gp_dir;
   assign val   = port_own ? port_val : gp_val;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= RST_OUT;
         pin_oe  <= 1'b0;
      end else begin
         // open-drain only pulls low
         pin_out <= odrain ? 1'b0 : val;
         pin_oe  <= odrain ? (drive & ~val) : drive;
      end
   end
endmodule
`default_nettype wire

/* File: src/spimsp_top.v */
// serial peripheral port, master or slave, with APB register slave
// Function
// - master clock is bus clock divided 2..256
// - divider runs only during master transfers
// - eight shifts exchange both bytes in ring
// - written byte goes out, read returns received
// - inputs forced, outputs need direction bit
// - polarity bit sets idle clock level
// - phase bit picks sampling edge
// - select output low during each transfer
// - select pin function from direction and enable
// - bidirectional mode shares one data pin
// - single pin bit frees other data pin
// - interrupt on done or fault when enabled
// - enable clear resets, set claims pins
// - enable reads zero during mode fault
// - master bit reads zero during mode fault
// - wired-or bit makes pins open-drain
// - order bit picks msb or lsb first
// - done flag after eighth clock, cleared
// - select low in master sets fault when its direction bit is clear
// - write while busy blocked, collision flag
// - rate resets to divide by two
`include "spimsp_map.vh"
`default_nettype none
module spimsp_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         irq,
   input  wire        miso_in,
   output wire        miso_out,
   output wire        miso_oe,
   input  wire        mosi_in,
   output wire        mosi_out,
   output wire        mosi_oe,
   input  wire        sck_in,
   output wire        sck_out,
   output wire        sck_oe,
   input  wire        ss_in,
   output wire        ss_out,
   output wire        ss_oe
);
   reg  [7:0] ctl_ff;
   reg        single_pin_mode_select_ff;
   reg  [2:0] spr_ff;
   reg  [3:0] dir_ff;
   reg  [3:0] gpo_ff;
   reg        done_ff;
   reg        write_collision_flag_ff;
   reg        mode_fault_flag_ff;
   reg        arm_done_ff;
   reg        arm_write_collision_flag_ff;
   reg        arm_mode_fault_flag_ff;
   reg  [7:0] rdbuf_ff;
   reg  [7:0] sh_ff;
   reg        dout_ff;
   reg        mbusy_ff;
   reg  [3:0] edge_ff;
   reg  [7:0] div_ff;
   reg        sck_ff;
   reg        sck_prev_ff;
   reg  [2:0] scnt_ff;
   reg  [31:0] nxt_rdata;
   reg        nxt_err;

   wire miso_s;
   wire mosi_s;
   wire sck_s;
   wire ss_s;
   spimsp_sync #(.INIT(1'b0)) u_sync_miso (.pclk(pclk), .presetn(presetn),
      .pin_in(miso_in), .level(miso_s));
   spimsp_sync #(.INIT(1'b0)) u_sync_mosi (.pclk(pclk), .presetn(presetn),
      .pin_in(mosi_in), .level(mosi_s));
   spimsp_sync #(.INIT(1'b0)) u_sync_sck (.pclk(pclk), .presetn(presetn),
      .pin_in(sck_in), .level(sck_s));
   spimsp_sync #(.INIT(1'b1)) u_sync_ss (.pclk(pclk), .presetn(presetn),
      .pin_in(ss_in), .level(ss_s));

   wire en    = ctl_ff[`SPIMSP_C1_ENABLE];
   wire master_select  = ctl_ff[`SPIMSP_C1_MASTER];
   wire clock_polarity  = ctl_ff[`SPIMSP_C1_CLOCK_POLARITY];
   wire clock_phase  = ctl_ff[`SPIMSP_C1_CLOCK_PHASE];
   wire select_output_enable  = ctl_ff[`SPIMSP_C1_SELECT_OUTPUT_ENABLE];
   wire lsb_first_select  = ctl_ff[`SPIMSP_C1_LSB_FIRST_SELECT];
   wire odr   = ctl_ff[`SPIMSP_C1_ODRAIN];
   wire ssdir = dir_ff[`SPIMSP_PIN_SS];

   // apb decode: answer is registered in the setup cycle
   wire setup = psel & ~penable;
   wire acc   = psel & penable & pready;
   wire wr    = acc & pwrite;
   wire rd    = acc & ~pwrite;
   wire wr_c1 = wr & (paddr == `SPIMSP_OFF_CTL1);
   wire wr_dr = wr & (paddr == `SPIMSP_OFF_DATA);
   wire rd_dr = rd & (paddr == `SPIMSP_OFF_DATA);
   wire rd_fl = rd & (paddr == `SPIMSP_OFF_FLAG);
   wire dr_acc = wr_dr | rd_dr;

   // master bit clock: half period is 2^rate bus cycles
   wire [7:0] div_lim = (8'h01 << spr_ff) - 8'h01;
   wire       tick    = mbusy_ff & (div_ff == div_lim);
   wire m_smp = tick & (edge_ff[0] == clock_phase);
   wire m_shf = tick & (edge_ff[0] != clock_phase);
   wire m_end = tick & (edge_ff == `SPIMSP_LAST_EDGE);

   // slave side works from the synchronised clock
   wire s_act  = en & ~master_select & ~ss_s;
   wire s_edge = s_act & (sck_s ^ sck_prev_ff);
   wire s_lead = sck_s ^ clock_polarity;
   wire s_smp  = s_edge & (s_lead ^ clock_phase);
   wire s_shf  = s_edge & ~(s_lead ^ clock_phase);
   wire s_end  = s_smp & (scnt_ff == `SPIMSP_LAST_BIT);

   // single pin mode moves the data input to the shared pin
   wire din   = master_select ? (single_pin_mode_select_ff ? mosi_s : miso_s)
                     : (single_pin_mode_select_ff ? miso_s : mosi_s);
   wire smp   = m_smp | s_smp;
   wire shf   = m_shf | s_shf;
   wire [7:0] sh_nxt = lsb_first_select ? {din, sh_ff[7:1]} : {sh_ff[6:0], din};
   wire top   = lsb_first_select ? sh_ff[0] : sh_ff[7];
   wire xend  = m_end | s_end;
   wire busy  = mbusy_ff | (s_act & (scnt_ff != 3'h0));
   wire fault = en & master_select & ~ssdir & ~ss_s;

   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_err   = 1'b0;
      case (paddr)
         `SPIMSP_OFF_CTL1: begin
            nxt_rdata[7:0] = ctl_ff;
            nxt_rdata[`SPIMSP_C1_ENABLE] = en & ~mode_fault_flag_ff;
            nxt_rdata[`SPIMSP_C1_MASTER] = master_select & ~mode_fault_flag_ff;
         end
         `SPIMSP_OFF_CTL2: nxt_rdata[0] = single_pin_mode_select_ff;
         `SPIMSP_OFF_RATE: nxt_rdata[2:0] = spr_ff;
         `SPIMSP_OFF_FLAG: begin
            nxt_rdata[`SPIMSP_FL_DONE] = done_ff;
            nxt_rdata[`SPIMSP_FL_WRITE_COLLISION_FLAG] = write_collision_flag_ff;
            nxt_rdata[`SPIMSP_FL_MODE_FAULT_FLAG] = mode_fault_flag_ff;
         end
         `SPIMSP_OFF_DATA: nxt_rdata[7:0] = rdbuf_ff;
         `SPIMSP_OFF_PORT: nxt_rdata[3:0] =
            (dir_ff & gpo_ff) | (~dir_ff & {ss_s, sck_s, mosi_s, miso_s});
         `SPIMSP_OFF_DIR:  nxt_rdata[3:0] = dir_ff;
         default: nxt_err = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & nxt_err;
         if (setup) begin
            prdata  <= nxt_rdata;
         end
      end
   end

   // control registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_ff  <= `SPIMSP_RST_CTL1;
         single_pin_mode_select_ff <= 1'b0;
         spr_ff  <= `SPIMSP_RST_RATE;
         dir_ff  <= `SPIMSP_RST_DIR;
         gpo_ff  <= 4'h0;
      end else begin
         if (wr_c1) begin
            ctl_ff <= pwdata[7:0];
         end
         if (wr & (paddr == `SPIMSP_OFF_CTL2)) begin
            single_pin_mode_select_ff <= pwdata[0];
         end
         if (wr & (paddr == `SPIMSP_OFF_RATE)) begin
            spr_ff <= pwdata[2:0];
         end
         if (wr & (paddr == `SPIMSP_OFF_PORT)) begin
            gpo_ff <= pwdata[3:0];
         end
         if (wr & (paddr == `SPIMSP_OFF_DIR)) begin
            dir_ff <= pwdata[3:0];
         end
         // a mode fault drops out of master and releases the driven pins
         if (fault) begin
            ctl_ff[`SPIMSP_C1_ENABLE] <= 1'b0;
            ctl_ff[`SPIMSP_C1_MASTER] <= 1'b0;
            dir_ff[3:1] <= 3'h0;
         end
      end
   end

   // flags: a set in the same cycle as its clear wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_ff     <= 1'b0;
         write_collision_flag_ff     <= 1'b0;
         mode_fault_flag_ff     <= 1'b0;
         arm_done_ff <= 1'b0;
         arm_write_collision_flag_ff <= 1'b0;
         arm_mode_fault_flag_ff <= 1'b0;
         irq         <= 1'b0;
      end else begin
         if (rd_fl & prdata[`SPIMSP_FL_DONE]) begin
            arm_done_ff <= 1'b1;
         end else if (dr_acc) begin
            arm_done_ff <= 1'b0;
         end
         if (rd_fl & prdata[`SPIMSP_FL_WRITE_COLLISION_FLAG]) begin
            arm_write_collision_flag_ff <= 1'b1;
         end else if (dr_acc) begin
            arm_write_collision_flag_ff <= 1'b0;
         end
         if (rd_fl & prdata[`SPIMSP_FL_MODE_FAULT_FLAG]) begin
            arm_mode_fault_flag_ff <= 1'b1;
         end else if (wr_c1) begin
            arm_mode_fault_flag_ff <= 1'b0;
         end
         if (xend) begin
            done_ff <= 1'b1;
         end else if (dr_acc & arm_done_ff) begin
            done_ff <= 1'b0;
         end
         if (wr_dr & busy) begin
            write_collision_flag_ff <= 1'b1;
         end else if (dr_acc & arm_write_collision_flag_ff) begin
            write_collision_flag_ff <= 1'b0;
         end
         if (fault) begin
            mode_fault_flag_ff <= 1'b1;
         end else if (wr_c1 & arm_mode_fault_flag_ff) begin
            mode_fault_flag_ff <= 1'b0;
         end
         irq <= ctl_ff[`SPIMSP_C1_IRQEN] & (done_ff | mode_fault_flag_ff);
      end
   end

   // shift engine shared by master and slave
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_ff       <= 8'h00;
         rdbuf_ff    <= 8'h00;
         dout_ff     <= 1'b0;
         mbusy_ff    <= 1'b0;
         edge_ff     <= 4'h0;
         div_ff      <= 8'h00;
         sck_ff      <= 1'b0;
         sck_prev_ff <= 1'b0;
         scnt_ff     <= 3'h0;
      end else begin
         sck_prev_ff <= sck_s;
         if (!mbusy_ff | tick) begin
            div_ff <= 8'h00;
         end else begin
            div_ff <= div_ff + 8'h01;
         end
         if (!mbusy_ff) begin
            sck_ff <= clock_polarity;
         end else if (tick) begin
            sck_ff  <= ~sck_ff;
            edge_ff <= edge_ff + 4'h1;
         end
         if (smp) begin
            sh_ff <= sh_nxt;
         end
         if (shf) begin
            dout_ff <= top;
         end
         if (s_smp) begin
            scnt_ff <= scnt_ff + 3'h1;
         end
         if (xend) begin
            rdbuf_ff <= smp ? sh_nxt : sh_ff;
         end
         if (m_end) begin
            mbusy_ff <= 1'b0;
         end
         if (en & ~master_select & ss_s) begin
            scnt_ff <= 3'h0;
            dout_ff <= top;
         end
         if (wr_dr & ~busy) begin
            sh_ff   <= pwdata[7:0];
            dout_ff <= lsb_first_select ? pwdata[0] : pwdata[7];
            if (en & master_select & ~mode_fault_flag_ff) begin
               mbusy_ff <= 1'b1;
               edge_ff  <= 4'h0;
            end
         end
         // disabling or a fault stops and reinitialises the engine
         if (!en | fault) begin
            mbusy_ff <= 1'b0;
            edge_ff  <= 4'h0;
            scnt_ff  <= 3'h0;
         end
      end
   end

   // pin functions
   wire own_miso = en & ~(single_pin_mode_select_ff & master_select);
   wire own_mosi = en & ~(single_pin_mode_select_ff & ~master_select);
   wire own_ss   = en & ~(master_select & ssdir & ~select_output_enable);
   wire drv_miso = ~master_select & ~ss_s & dir_ff[`SPIMSP_PIN_MISO];
   wire drv_mosi = master_select & dir_ff[`SPIMSP_PIN_MOSI];
   wire drv_sck  = master_select & dir_ff[`SPIMSP_PIN_SCK];
   wire drv_ss   = master_select & ssdir & select_output_enable;

   spimsp_pin #(.RST_OUT(1'b0)) u_pin_miso (.pclk(pclk), .presetn(presetn),
      .port_own(own_miso), .port_drive(drv_miso), .port_val(dout_ff),
      .gp_dir(dir_ff[`SPIMSP_PIN_MISO]), .gp_val(gpo_ff[`SPIMSP_PIN_MISO]),
      .odrain(odr), .pin_out(miso_out), .pin_oe(miso_oe));
   spimsp_pin #(.RST_OUT(1'b0)) u_pin_mosi (.pclk(pclk), .presetn(presetn),
      .port_own(own_mosi), .port_drive(drv_mosi), .port_val(dout_ff),
      .gp_dir(dir_ff[`SPIMSP_PIN_MOSI]), .gp_val(gpo_ff[`SPIMSP_PIN_MOSI]),
      .odrain(odr), .pin_out(mosi_out), .pin_oe(mosi_oe));
   spimsp_pin #(.RST_OUT(1'b0)) u_pin_sck (.pclk(pclk), .presetn(presetn),
      .port_own(en), .port_drive(drv_sck), .port_val(sck_ff),
      .gp_dir(dir_ff[`SPIMSP_PIN_SCK]), .gp_val(gpo_ff[`SPIMSP_PIN_SCK]),
      .odrain(odr), .pin_out(sck_out), .pin_oe(sck_oe));
   spimsp_pin #(.RST_OUT(1'b1)) u_pin_ss (.pclk(pclk), .presetn(presetn),
      .port_own(own_ss), .port_drive(drv_ss), .port_val(~mbusy_ff),
      .gp_dir(ssdir), .gp_val(gpo_ff[`SPIMSP_PIN_SS]),
      .odrain(odr), .pin_out(ss_out), .pin_oe(ss_oe));
endmodule
`default_nettype wire

/* File: verif/spimsp_top_asserts.sv */
// assertion checker for the serial port top, bound to its ports
`include "spimsp_map.vh"
`default_nettype none
module spimsp_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sck_out,
   input wire logic        ss_out,
   input wire logic        ss_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup;
   assign setup = psel && !penable;
   property p_rdy; setup |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_map_ok;
      setup && paddr <= `SPIMSP_OFF_DIR && paddr[1:0] == 2'b00 |=> !pslverr;
   endproperty
   a_map_ok: assert property (p_map_ok) else $error("error on mapped address");
   property p_map_bad; setup && paddr > `SPIMSP_OFF_DIR |=> pslverr; endproperty
   a_map_bad: assert property (p_map_bad) else $error("no error on unmapped address");
   property p_rd_hold; !setup |=> $stable(prdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside setup");
   // clock edges only inside a select frame
   property p_ss_frame; ss_oe && $changed(sck_out) |-> !$past(ss_out); endproperty
   a_ss_frame: assert property (p_ss_frame) else $error("clock edge while deselected");
   property p_sck_idle; (ss_oe && ss_out) [*3] |-> $stable(sck_out); endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock runs while idle");
   c_xfer: cover property (ss_oe && $fell(ss_out));
   c_err: cover property (pslverr);
   c_sck: cover property (ss_oe && $changed(sck_out));
endmodule
bind spimsp_top spimsp_chk spimsp_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sck_out(sck_out), .ss_out(ss_out), .ss_oe(ss_oe));
`default_nettype wire

/* File: verif/spimsp_slave_model.sv */
// behavioural spi slave, mode zero, msb first, answers a preset byte
`default_nettype none
module spimsp_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   input  wire logic [7:0] tx_byte,
   output var  logic       miso,
   output var  logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh = 8'h00;
   initial miso = 1'b0;
   initial rx_byte = 8'h00;
   always @(negedge ss_n) begin
      sh = tx_byte;
      miso = tx_byte[7];
   end
   // sample on the leading edge, shift on the trailing edge
   always @(posedge sck) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge sck) if (!ss_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
   end
   // released line shows the inverse of its last level
   always @(posedge ss_n) miso = ~miso;
endmodule
`default_nettype wire

/* File: verif/spimsp_top_tb.sv */
// self-checking bench: register access and transfers against a slave model
`include "spimsp_map.vh"
`default_nettype none
module spimsp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        ss_low = 1'b0;
   logic        last_err;
   time         t0;
   int          mismatches = 0;
   int          check_count = 0;
   int          cyc = 0;
   wire [31:0]  prdata;
   wire         pready, pslverr, irq, slv_miso;
   wire         miso_out, miso_oe, mosi_out, mosi_oe, sck_out, sck_oe, ss_out, ss_oe;
   wire [7:0]   slv_rx;
   wire         miso_w = miso_oe ? miso_out : slv_miso;
   wire         mosi_w = mosi_oe ? mosi_out : 1'b1;
   wire         sck_w = sck_oe ? sck_out : 1'b0;
   wire         ss_w = ss_oe ? ss_out : !ss_low;
   always #20 pclk = ~pclk;
   spimsp_top spimsp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .mosi_in(mosi_w),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe(sck_oe), .ss_in(ss_w), .ss_out(ss_out), .ss_oe(ss_oe));
   spimsp_slave_model spimsp_slave_model_inst (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
      .tx_byte(8'h1e), .miso(slv_miso), .rx_byte(slv_rx));
   task automatic end_of_test();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 8'h00, q);
      chk(q, {24'h00_0000, exp});
   endtask
   task automatic wait_done();
      logic [31:0] q;
      q = 32'h0000_0000;
      for (int n = 0; n < 300 && !q[7]; n++) apb(1'b0, `SPIMSP_OFF_FLAG, 8'h00, q);
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(`SPIMSP_OFF_CTL1, 8'h00);
      rdc(`SPIMSP_OFF_RATE, 8'h00);
      rdc(`SPIMSP_OFF_FLAG, 8'h00);
      rdc(8'h1c, 8'h00);
      chk({31'h0, last_err}, 32'h1);
      wr(`SPIMSP_OFF_DIR, 8'h04);
      wr(`SPIMSP_OFF_CTL1, 8'h58);
      repeat (3) @(posedge pclk);
      chk({31'h0, sck_out}, 32'h1);
      // pass 0: msb first with a colliding write, pass 1: lsb first with irq on
      for (int i = 0; i < 2; i++) begin
         wr(`SPIMSP_OFF_CTL1, i ? 8'hd3 : 8'h52);
         wr(`SPIMSP_OFF_RATE, 8'(3 + i));
         wr(`SPIMSP_OFF_DIR, 8'h0f);
         wr(`SPIMSP_OFF_DATA, 8'hb1);
         if (i == 0) wr(`SPIMSP_OFF_DATA, 8'hff);
         @(posedge sck_out);
         t0 = $time;
         chk({31'h0, ss_out}, 32'h0);
         chk({31'h0, miso_oe}, 32'h0);
         @(negedge sck_out);
         chk(32'($time - t0), 32'(320 << i));
         wait_done();
         chk({31'h0, irq}, 32'(i));
         rdc(`SPIMSP_OFF_FLAG, i ? 8'h80 : 8'hc0);
         rdc(`SPIMSP_OFF_DATA, i ? 8'h78 : 8'h1e);
         chk({24'h0, slv_rx}, i ? 32'h8d : 32'hb1);
         rdc(`SPIMSP_OFF_FLAG, 8'h00);
         chk({31'h0, ss_out}, 32'h1);
      end
      wr(`SPIMSP_OFF_DIR, 8'h06);
      wr(`SPIMSP_OFF_CTL1, 8'hd0);
      ss_low <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rdc(`SPIMSP_OFF_FLAG, 8'h10);
      rdc(`SPIMSP_OFF_CTL1, 8'h80);
      ss_low <= 1'b0;
      wr(`SPIMSP_OFF_CTL1, 8'h00);
      rdc(`SPIMSP_OFF_FLAG, 8'h00);
      // port disabled: all four pins are general outputs, then open-drain
      wr(`SPIMSP_OFF_PORT, 8'h05);
      wr(`SPIMSP_OFF_DIR, 8'h0f);
      repeat (2) @(posedge pclk);
      chk({24'h0, ss_oe, ss_out, sck_oe, sck_out, mosi_oe, mosi_out, miso_oe, miso_out},
          32'h0000_00bb);
      rdc(`SPIMSP_OFF_PORT, 8'h05);
      wr(`SPIMSP_OFF_CTL1, 8'h20);
      repeat (2) @(posedge pclk);
      chk({24'h0, ss_oe, ss_out, sck_oe, sck_out, mosi_oe, mosi_out, miso_oe, miso_out},
          32'h0000_0088);
      wr(`SPIMSP_OFF_CTL2, 8'h01);
      rdc(`SPIMSP_OFF_CTL2, 8'h01);
      end_of_test();
   end
endmodule
`default_nettype wire
